/* chamber_consts.vh */
// register offsets, field positions, reset values and timing counts for the chamber event interlock
// assumes a 32-bit axi4-lite slave with word-aligned registers
`ifndef CHAMBER_CONSTS_VH
`define CHAMBER_CONSTS_VH

// ********
// register byte offsets
// ********
`define OFS_EVENT        8'h00
`define OFS_CONFIG       8'h04
`define OFS_POSITION     8'h08
`define OFS_CUST_EVENT   8'h0c
`define OFS_REMOTE_SP    8'h10
`define OFS_DOUT_MODE    8'h14
`define OFS_STATUS       8'h18
`define OFS_OUTPUTS      8'h1c
`define OFS_ALT_LIMIT    8'h20

// ********
// event register fields
// ********
`define EV_CHAMBER       0
`define EV_HUMIDITY      1
`define EV_PURGE         2
`define EV_ALTITUDE      3
`define EV_DEFROST       4
`define EV_PRODUCT       5
`define EV_UPDATE        6

// ********
// config register fields
// ********
`define CF_PURGE_OPT     0
`define CF_HUMID_OPT     1
`define CF_LOWRH_OPT     2
`define CF_WET_VACUUM    3
`define CF_HOTGAS_OPT    4
`define CF_THREE_POS     5
`define CF_LEFT_RIGHT    6

// ********
// position register fields (write one to select)
// ********
`define POS_WARM         0
`define POS_CHILL        1
`define POS_AMBIENT      2

// ********
// reset values and timing
// ********
`define DOUT_MODE_RESET  16'hffff
`define ALT_LIMIT_RESET  32'h0000fde8
`define XFER_TIMEOUT_MS  1000
`define CLK_MHZ          50
`define XFER_TIMEOUT_CYC (`XFER_TIMEOUT_MS * 1000 * `CLK_MHZ)

`endif

/* transfer_shuttle.v */
// transfer mechanism control: one-hot position events, travel timeout, toggle mode
// assumes position feedback levels are synchronous to aclk
`timescale 1ns/1ns
`include "chamber_consts.vh"

module transfer_shuttle #(
  parameter TIMEOUT_CYC = `XFER_TIMEOUT_CYC
) (
  // clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // selection
  input  wire       sel_wr,
  input  wire [2:0] sel_data,
  input  wire       update,
  input  wire       three_pos,
  // feedback
  input  wire [2:0] at_pos,
  // results
  output reg  [2:0] drive_reg,
  output reg        fault_reg,
  output reg        toggle_reg
);

  reg  [31:0] timer_reg;
  reg  [2:0]  pos_mask;
  reg  [2:0]  pick;

  // ********
  // selection decode
  // ********
  always @* begin
    pos_mask = three_pos ? 3'h7 : 3'h3;  // [RQ10]
    pick     = 3'h0;
    if (sel_data[`POS_WARM])
      pick = 3'h1;
    else if (sel_data[`POS_CHILL])
      pick = 3'h2;
    else if (sel_data[`POS_AMBIENT])
      pick = 3'h4;
    pick = pick & pos_mask;
  end

  // ********
  // position state
  // ********
  always @(posedge aclk) begin
    if (!aresetn) begin
      drive_reg  <= 3'h0;
      fault_reg  <= 1'b0;
      toggle_reg <= 1'b0;
      timer_reg  <= 32'h0;
    end else if (sel_wr) begin
      // both warm and chill requested: alternate on each update
      toggle_reg <= sel_data[`POS_WARM] & sel_data[`POS_CHILL];  // [RQ14]
      drive_reg  <= pick;  // [RQ11]
      fault_reg  <= 1'b0;
      timer_reg  <= 32'h0;
    end else begin
      if (update && toggle_reg && drive_reg != 3'h0)
        drive_reg <= (drive_reg == 3'h1) ? 3'h2 : 3'h1;  // [RQ14]
      if (drive_reg == 3'h0 || (drive_reg & at_pos) != 3'h0 || update)
        timer_reg <= 32'h0;
      else if (timer_reg >= TIMEOUT_CYC - 1) begin
        fault_reg  <= 1'b1;  // [RQ12]
        drive_reg  <= 3'h0;  // [RQ13]
        toggle_reg <= 1'b0;  // [RQ13]
        timer_reg  <= 32'h0;
      end else
        timer_reg <= timer_reg + 32'h1;
    end
  end

endmodule // transfer_shuttle

/* chamber_event_interlock.v */
// chamber event interlock: event switches gated by options and interlocks into actuator outputs
// assumes an axi4-lite master on aclk, and status inputs synchronous to aclk
//
// Operation
// RQ1: purge-only option: dryer follows purge event.
// RQ2: dryer never runs while chamber event is off.
// RQ3: humidity option with humidity enabled forces purge off.
// RQ4: with humidity enabled, low dewpoint limit turns purge back on.
// RQ5: low RH option: frozen coil and purge run together on low humidity demand.
// RQ6: low RH option: manual purge only while humidity disabled.
// RQ7: altitude event drives altitude outputs without chamber event.
// RQ8: heat and cool inhibited when altitude exceeds limit.
// RQ9: altitude enabled inhibits humidity unless vacuum is moisture tolerant.
// RQ10: transfer supports two or three shuttle positions.
// RQ11: selecting a position clears others and commands the basket there.
// RQ12: basket not reaching position raises transfer fault.
// RQ13: after fault, selection cleared; no retry until new selection.
// RQ14: warm and chill both requested: each update toggles position.
// RQ15: sequencer should request one transfer position per step.
// RQ16: defrost event starts defrost when hot-gas option fitted.
// RQ17: each remote set point event makes its input replace the loop target.
// RQ18: product loop event enables product control, manual or program.
// RQ19: up to 15 customer event relays, manual or program.
// RQ20: digital outputs follow customer events only in event mode; default event mode.
// RQ21: all actuator outputs registered and cleared by reset.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "chamber_consts.vh"

module chamber_event_interlock #(
  parameter NUM_CUST    = 15,
  parameter NUM_REMOTE  = 4,
  parameter TIMEOUT_CYC = `XFER_TIMEOUT_CYC
) (
  // clock and reset
  input  wire                  aclk,
  input  wire                  aresetn,
  // axi4-lite write address
  input  wire [7:0]            s_axi_awaddr,
  input  wire                  s_axi_awvalid,
  output reg                   s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output reg                   s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]            s_axi_bresp,
  output reg                   s_axi_bvalid,
  input  wire                  s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]            s_axi_araddr,
  input  wire                  s_axi_arvalid,
  output reg                   s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]           s_axi_rdata,
  output reg  [1:0]            s_axi_rresp,
  output reg                   s_axi_rvalid,
  input  wire                  s_axi_rready,
  // sequencer event inputs
  input  wire                  prog_running,
  input  wire [6:0]            prog_events,
  input  wire [NUM_CUST-1:0]   prog_cust_events,
  input  wire [NUM_REMOTE-1:0] prog_remote_sp,
  // chamber conditions
  input  wire                  low_dewpoint_limit,
  input  wire                  low_rh_demand,
  input  wire [31:0]           altitude_ft,
  input  wire [2:0]            at_position,
  // actuator outputs
  output reg                   chamber_run,
  output reg                   heat_cool_enable,
  output reg                   humidity_enable,
  output reg                   air_dryer,
  output reg                   frozen_coil,
  output reg                   altitude_enable,
  output reg                   defrost_start,
  output reg                   product_control,
  output reg  [NUM_REMOTE-1:0] analog_target_override,
  output reg  [NUM_CUST-1:0]   cust_relay,
  output reg  [NUM_CUST-1:0]   digital_out,
  output reg                   move_to_warm_zone,
  output reg                   move_to_chill_zone,
  output reg                   ambient_load_position,
  output reg                   move_to_port_side,
  output reg                   move_to_starboard_side,
  output reg                   transfer_fault
);

  // ********
  // register state
  // ********
  reg  [6:0]            event_reg;
  reg  [6:0]            config_reg;
  reg  [NUM_CUST-1:0]   cust_reg;
  reg  [NUM_REMOTE-1:0] remote_reg;
  reg  [NUM_CUST-1:0]   dout_mode_reg;
  reg  [31:0]           alt_limit_reg;
  reg                   aw_held_reg;
  reg  [7:0]            aw_addr_reg;
  reg                   w_held_reg;
  reg  [31:0]           w_data_reg;
  reg  [3:0]            w_strb_reg;
  reg                   sel_wr_reg;
  reg  [2:0]            sel_data_reg;
  reg                   defrost_arm_reg;

  wire [2:0]            drive;
  wire                  fault;
  wire                  toggle;

  // merges byte lanes of a write into an old word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer      i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction

  // address is one of the mapped words
  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `OFS_ALT_LIMIT);
    end
  endfunction

  // ********
  // axi4-lite write channel
  // ********
  wire       do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire [31:0] wword;
  assign wword = merge(32'h0, w_data_reg, w_strb_reg);
  // wide merges cut to each register's width on purpose
  wire [31:0] ev_m    = merge({25'h0, event_reg}, w_data_reg, w_strb_reg);
  wire [31:0] cust_m  = merge({{(32-NUM_CUST){1'b0}}, cust_reg}, w_data_reg, w_strb_reg);
  wire [31:0] rsp_m   = merge({{(32-NUM_REMOTE){1'b0}}, remote_reg}, w_data_reg, w_strb_reg);
  wire [31:0] dmode_m = merge({{(32-NUM_CUST){1'b0}}, dout_mode_reg}, w_data_reg, w_strb_reg);
  wire [15:0] dout_rst = `DOUT_MODE_RESET;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_held_reg   <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_held_reg    <= 1'b0;
      w_data_reg    <= 32'h0;
      w_strb_reg    <= 4'h0;
      event_reg     <= 7'h00;
      config_reg    <= 7'h00;
      cust_reg      <= {NUM_CUST{1'b0}};
      remote_reg    <= {NUM_REMOTE{1'b0}};
      dout_mode_reg <= dout_rst[NUM_CUST-1:0];  // [RQ20]
      alt_limit_reg <= `ALT_LIMIT_RESET;
      sel_wr_reg    <= 1'b0;
      sel_data_reg  <= 3'h0;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      sel_wr_reg <= 1'b0;
      // update is a self-clearing strobe
      event_reg[`EV_UPDATE] <= 1'b0;
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_reg) ? 2'b00 : 2'b10;
        case (aw_addr_reg)
          `OFS_EVENT:      event_reg     <= ev_m[6:0];
          `OFS_CONFIG:     config_reg    <= wword[6:0] | (config_reg & ~{7{w_strb_reg[0]}});
          `OFS_POSITION: begin
            sel_wr_reg   <= w_strb_reg[0];  // [RQ11]
            sel_data_reg <= w_data_reg[2:0];
          end
          `OFS_CUST_EVENT: cust_reg      <= cust_m[NUM_CUST-1:0];
          `OFS_REMOTE_SP:  remote_reg    <= rsp_m[NUM_REMOTE-1:0];
          `OFS_DOUT_MODE:  dout_mode_reg <= dmode_m[NUM_CUST-1:0];
          `OFS_ALT_LIMIT:  alt_limit_reg <= merge(alt_limit_reg, w_data_reg, w_strb_reg);
          default: ;
        endcase
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ********
  // axi4-lite read channel
  // ********
  reg [31:0] rword;
  always @* begin
    rword = 32'h0;
    case (s_axi_araddr)
      `OFS_EVENT:      rword = {25'h0, event_reg};
      `OFS_CONFIG:     rword = {25'h0, config_reg};
      `OFS_POSITION:   rword = {29'h0, drive};
      `OFS_CUST_EVENT: rword = {{(32-NUM_CUST){1'b0}}, cust_reg};
      `OFS_REMOTE_SP:  rword = {{(32-NUM_REMOTE){1'b0}}, remote_reg};
      `OFS_DOUT_MODE:  rword = {{(32-NUM_CUST){1'b0}}, dout_mode_reg};
      `OFS_STATUS:     rword = {29'h0, toggle, fault, altitude_ft > alt_limit_reg};
      `OFS_OUTPUTS:    rword = {24'h0, defrost_start, altitude_enable, frozen_coil,
                                air_dryer, humidity_enable, heat_cool_enable,
                                product_control, chamber_run};
      `OFS_ALT_LIMIT:  rword = alt_limit_reg;
      default:         rword = 32'h0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rword;
        s_axi_rresp   <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ********
  // transfer mechanism
  // ********
  transfer_shuttle #(
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_shuttle (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .sel_wr     (sel_wr_reg),
    .sel_data   (sel_data_reg),
    .update     (event_reg[`EV_UPDATE]),
    .three_pos  (config_reg[`CF_THREE_POS]),  // [RQ10]
    .at_pos     (at_position),
    .drive_reg  (drive),
    .fault_reg  (fault),
    .toggle_reg (toggle)
  );

  // ********
  // interlock logic
  // ********
  // manual and program sources are or-ed; program bits count only while it runs
  wire [6:0] ev = event_reg | (prog_running ? prog_events : 7'h00);  // [RQ18]
  wire       chamber_on  = ev[`EV_CHAMBER];
  wire       alt_on      = ev[`EV_ALTITUDE];
  wire       alt_over    = altitude_ft > alt_limit_reg;
  wire       humid_on    = chamber_on && config_reg[`CF_HUMID_OPT] && ev[`EV_HUMIDITY]
                           && !(alt_on && !config_reg[`CF_WET_VACUUM]);  // [RQ9]
  wire       lowrh_opt   = config_reg[`CF_LOWRH_OPT];
  wire       lowrh_run   = lowrh_opt && humid_on && low_rh_demand;  // [RQ5]
  reg        purge_next;

  always @* begin
    purge_next = 1'b0;
    if (lowrh_opt) begin
      if (humid_on)
        purge_next = lowrh_run;  // [RQ5]
      else
        purge_next = ev[`EV_PURGE];  // [RQ6]
    end else if (config_reg[`CF_PURGE_OPT]) begin
      if (humid_on)
        purge_next = ev[`EV_PURGE] && low_dewpoint_limit;  // [RQ3] [RQ4]
      else
        purge_next = ev[`EV_PURGE];  // [RQ1]
    end
    purge_next = purge_next && chamber_on;  // [RQ2]
  end

  always @(posedge aclk) begin
    if (!aresetn) begin  // [RQ21]
      chamber_run            <= 1'b0;
      heat_cool_enable       <= 1'b0;
      humidity_enable        <= 1'b0;
      air_dryer              <= 1'b0;
      frozen_coil            <= 1'b0;
      altitude_enable        <= 1'b0;
      defrost_start          <= 1'b0;
      defrost_arm_reg        <= 1'b0;
      product_control        <= 1'b0;
      analog_target_override <= {NUM_REMOTE{1'b0}};
      cust_relay             <= {NUM_CUST{1'b0}};
      digital_out            <= {NUM_CUST{1'b0}};
      move_to_warm_zone      <= 1'b0;
      move_to_chill_zone     <= 1'b0;
      ambient_load_position  <= 1'b0;
      move_to_port_side      <= 1'b0;
      move_to_starboard_side <= 1'b0;
      transfer_fault         <= 1'b0;
    end else begin
      chamber_run      <= chamber_on;
      heat_cool_enable <= chamber_on && !alt_over;  // [RQ8]
      humidity_enable  <= humid_on;  // [RQ9]
      air_dryer        <= purge_next;
      frozen_coil      <= lowrh_run && chamber_on;  // [RQ5]
      altitude_enable  <= alt_on;  // [RQ7]
      // one-cycle start pulse on a rising defrost request
      defrost_arm_reg  <= ev[`EV_DEFROST];
      defrost_start    <= config_reg[`CF_HOTGAS_OPT] && ev[`EV_DEFROST]
                          && !defrost_arm_reg;  // [RQ16]
      product_control  <= ev[`EV_PRODUCT];  // [RQ18]
      analog_target_override <= remote_reg
                                | (prog_running ? prog_remote_sp : {NUM_REMOTE{1'b0}});  // [RQ17]
      cust_relay       <= cust_reg
                          | (prog_running ? prog_cust_events : {NUM_CUST{1'b0}});  // [RQ19]
      digital_out      <= (cust_reg | (prog_running ? prog_cust_events : {NUM_CUST{1'b0}}))
                          & dout_mode_reg;  // [RQ20]
      move_to_warm_zone      <= !config_reg[`CF_LEFT_RIGHT] && drive[`POS_WARM];  // [RQ10]
      move_to_chill_zone     <= !config_reg[`CF_LEFT_RIGHT] && drive[`POS_CHILL];
      move_to_port_side      <= config_reg[`CF_LEFT_RIGHT] && drive[`POS_WARM];
      move_to_starboard_side <= config_reg[`CF_LEFT_RIGHT] && drive[`POS_CHILL];
      ambient_load_position  <= drive[`POS_AMBIENT];
      transfer_fault         <= fault;  // [RQ12]
    end
  end

endmodule // chamber_event_interlock

/* interlock_monitor.sv */
// checker on the interlock top-level outputs
// assumes it is bound to the top module and the altitude limit stays at reset
`timescale 1ns/1ns

module interlock_monitor #(
  parameter TIMEOUT_CYC = 20
) (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // conditions
  input wire [31:0] altitude_ft,
  input wire [2:0]  at_position,
  // outputs watched
  input wire        chamber_run,
  input wire        heat_cool_enable,
  input wire        air_dryer,
  input wire        frozen_coil,
  input wire        defrost_start,
  input wire        move_to_warm_zone,
  input wire        move_to_chill_zone,
  input wire        ambient_load_position,
  input wire        move_to_port_side,
  input wire        move_to_starboard_side,
  input wire        transfer_fault
);
  localparam int ALT_LIM = 65000;
  wire [4:0] mv  = {ambient_load_position, move_to_starboard_side, move_to_port_side,
                    move_to_chill_zone, move_to_warm_zone};
  wire [2:0] drv = {mv[4], mv[3] | mv[1], mv[2] | mv[0]};
  wire       miss = |(drv & ~at_position);
  logic [2:0]  drv_q;
  logic [31:0] miss_cnt;

  // ********
  // travel time counter, restarts on a new target
  // ********
  always @(posedge aclk) begin
    drv_q <= drv;
    if (!aresetn || !miss || drv != drv_q)
      miss_cnt <= 32'h0;
    else
      miss_cnt <= miss_cnt + 32'h1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_dryer_chamber: assert property (air_dryer |-> chamber_run)
    else $error("dryer on with chamber off");
  chk_coil_dryer: assert property (frozen_coil |-> air_dryer)
    else $error("frozen coil without dryer");
  chk_heat_inhibit: assert property ((altitude_ft > ALT_LIM) [*3] |-> !heat_cool_enable)
    else $error("heat or cool on above altitude limit");
  chk_move_onehot: assert property ($onehot0(mv))
    else $error("more than one position driven");
  chk_fault_nodrive: assert property (transfer_fault |-> mv == 5'h0)
    else $error("position driven during fault");
  chk_fault_timeout: assert property (miss_cnt <= TIMEOUT_CYC + 5)
    else $error("missed arrival without fault");
  chk_defrost_pulse: assert property (defrost_start |=> !defrost_start)
    else $error("defrost start longer than a pulse");
  chk_reset_clear: assert property (disable iff (1'b0) !aresetn |=>
    !(chamber_run | air_dryer | transfer_fault | (|mv)))
    else $error("output active after reset");

  cover property (air_dryer);
  cover property (frozen_coil);
  cover property (defrost_start);
  cover property ($rose(transfer_fault));
endmodule // interlock_monitor

bind chamber_event_interlock interlock_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) mon_u (.*);

/* shuttle_model.sv */
// basket mechanism with arrival sensors
// assumes one drive bit per zone from the interlock
`timescale 1ns/1ns

module shuttle_model (
  // clock
  input  wire        aclk,
  // commands
  input  wire [2:0]  drive,
  input  wire        stuck,
  input  wire [3:0]  travel,
  // sensors
  output logic [2:0] at_position
);
  logic [2:0] tgt = 3'h0;
  logic [3:0] cnt = 4'h0;
  initial at_position = 3'h0;
  // sensors read zero in transit; a stuck basket never arrives
  always @(posedge aclk) begin
    if (drive != 3'h0 && drive != tgt) begin
      tgt <= drive;
      cnt <= 4'h0;
      at_position <= 3'h0;
    end else if (drive != 3'h0 && !stuck && at_position != tgt) begin
      cnt <= cnt + 4'h1;
      if (cnt == travel) at_position <= tgt;
    end
  end
endmodule // shuttle_model

/* testbench.sv */
// self-checking bench for the chamber event interlock
// assumes the shuttle model on the position feedback
`timescale 1ns/1ns
`include "chamber_consts.vh"

module testbench;
  localparam TMO = 20;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, prog_running, low_dewpoint_limit, low_rh_demand, stuck;
  logic        chamber_run, heat_cool_enable, humidity_enable, air_dryer, frozen_coil;
  logic        altitude_enable, defrost_start, product_control, transfer_fault;
  logic        move_to_warm_zone, move_to_chill_zone, ambient_load_position;
  logic        move_to_port_side, move_to_starboard_side;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, altitude_ft;
  logic [3:0]  s_axi_wstrb, prog_remote_sp, analog_target_override, travel;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [6:0]  prog_events;
  logic [14:0] prog_cust_events, cust_relay, digital_out;
  logic [2:0]  at_position;
  int          err_total, num_checks, cycles, pulses;
  integer      seed = 32'hde1a9e08;
  wire [4:0]   mv = {ambient_load_position, move_to_starboard_side, move_to_port_side,
                     move_to_chill_zone, move_to_warm_zone};

  chamber_event_interlock #(.TIMEOUT_CYC(TMO)) dut_u (.*);

  shuttle_model model_u (.aclk, .stuck, .travel, .at_position,
    .drive({mv[4], mv[3] | mv[1], mv[2] | mv[0]}));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (defrost_start === 1'b1) pulses <= pulses + 1;
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      conclude;
    end
  end

  // ********
  // bus tasks, compare and expectations
  // ********
  task automatic check_val(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic settle;
    repeat (3) @(posedge aclk);
  endtask

  task automatic xfer(input logic [2:0] p, input logic [4:0] e);
    wr(`OFS_POSITION, {29'h0, p});
    settle;
    check_val(mv, e);
  endtask

  // returns {coil, dryer}; ev is {purge, humidity, chamber}
  function automatic logic [1:0] dry_exp(input logic [2:0] cfg, input logic [2:0] ev,
                                         input logic dp, input logic dm);
    logic hum;
    hum = ev[0] & ev[1] & cfg[1];
    if (cfg[2] && hum) return {dm, dm};
    if (hum) return {1'b0, ev[2] & dp};
    return {1'b0, ev[0] & ev[2]};
  endfunction

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    int i, k, p0;
    logic [2:0] cfg;
    logic [1:0] e, r;
    logic [31:0] d, a, b;
    logic m;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hf};
    {prog_running, prog_events, prog_cust_events, prog_remote_sp} = 27'h0;
    {low_dewpoint_limit, low_rh_demand, stuck, travel} = 7'h8;
    altitude_ft = 32'h3e8;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_val({chamber_run, air_dryer, transfer_fault, mv, cust_relay, digital_out}, 0);
    axi_rd(`OFS_ALT_LIMIT, d, r);
    check_val(d, 32'h0000fde8);
    axi_wr(8'h24, 32'h1, r);
    check_val(r, 2'h2);
    axi_rd(8'h24, d, r);
    check_val(r, 2'h2);
    for (i = 0; i < 24; i++) begin
      d = $random(seed);
      k = d[15:8] % 3;
      cfg = (k == 0) ? 3'h1 : (k == 1) ? 3'h3 : 3'h7;
      wr(`OFS_CONFIG, {29'h0, cfg});
      @(posedge aclk);
      {low_rh_demand, low_dewpoint_limit, prog_running} <= d[5:3];
      prog_events <= {1'b0, d[6], 2'h0, d[2:0]};
      wr(`OFS_EVENT, d[3] ? 32'h0 : {26'h0, d[6], 2'h0, d[2:0]});
      settle;
      e = dry_exp(cfg, d[2:0], d[4], d[5]);
      check_val(air_dryer, e[0]);
      check_val(frozen_coil, e[1]);
      check_val(product_control, d[6]);
    end
    @(posedge aclk);
    prog_running <= 1'b0;
    for (k = 0; k < 2; k++) begin
      wr(`OFS_CONFIG, k ? 32'ha : 32'h2);
      wr(`OFS_EVENT, 32'hb);
      settle;
      check_val(humidity_enable, k);
      altitude_ft <= 32'h0000fde9;
      settle;
      check_val(heat_cool_enable, 32'h0);
      altitude_ft <= 32'h0000fde8;
      settle;
      check_val(heat_cool_enable, 32'h1);
    end
    wr(`OFS_EVENT, 32'h8);
    settle;
    check_val({chamber_run, altitude_enable}, 32'h1);
    for (k = 0; k < 3; k++) begin
      wr(`OFS_CONFIG, k ? 32'h10 : 32'h0);
      p0 = pulses;
      if (k == 2) {prog_running, prog_events} <= 8'h90;
      else wr(`OFS_EVENT, 32'h10);
      settle;
      check_val(pulses - p0, k != 0);
      wr(`OFS_EVENT, 32'h0);
      prog_events <= 7'h0;
    end
    for (i = 0; i < 4; i++) begin
      a = $random(seed);
      b = $random(seed);
      m = (i == 0) || (i != 1 && b[31]);
      wr(`OFS_REMOTE_SP, {28'h0, a[3:0]});
      wr(`OFS_CUST_EVENT, {17'h0, a[18:4]});
      if (i != 0) wr(`OFS_DOUT_MODE, {16'h0, {16{m}}});
      {prog_cust_events, prog_remote_sp} <= b[18:0];
      settle;
      check_val(analog_target_override, a[3:0] | b[3:0]);
      check_val(cust_relay, a[18:4] | b[18:4]);
      check_val(digital_out, (a[18:4] | b[18:4]) & {15{m}});
    end
    prog_running <= 1'b0;
    wr(`OFS_CONFIG, 32'h0);
    // one position per selection, as a sequencer step would ask, except warm and chill together (3'h3) for toggle mode
    xfer(3'h1, 5'h01);
    repeat (30) @(posedge aclk);
    check_val({transfer_fault, mv}, 6'h01);
    xfer(3'h2, 5'h02);
    wr(`OFS_CONFIG, 32'h40);
    xfer(3'h1, 5'h04);
    xfer(3'h2, 5'h08);
    wr(`OFS_CONFIG, 32'h20);
    xfer(3'h4, 5'h10);
    wr(`OFS_CONFIG, 32'h0);
    travel <= 4'h1;
    xfer(3'h3, 5'h01);
    for (k = 0; k < 2; k++) begin
      wr(`OFS_EVENT, 32'h40);
      settle;
      check_val(mv, k ? 5'h01 : 5'h02);
    end
    stuck <= 1'b1;
    xfer(3'h2, 5'h02);
    repeat (30) @(posedge aclk);
    check_val({transfer_fault, mv}, 6'h20);
    stuck <= 1'b0;
    repeat (10) @(posedge aclk);
    check_val(mv, 5'h0);
    xfer(3'h1, 5'h01);
    check_val(transfer_fault, 1'b0);
    conclude;
  end
endmodule // testbench
